// ### verilog/drive_enable_fault_supervisor.sv
/*
 Enable and fault supervisor for one drive axis: software and hardware
 enable, active fault list, time-stamped fault history, mode register.
 Assumes fault_in, command and register inputs are synchronous to clk.
*/
`include "drive_params.svh"

// Notes on behaviour
// - After reset, load software enable from default unless source is 1.
// - Keep the last 50 faults, each with display code and time stamp.
// - The clear-history command empties the fault history.
// - A fault-list read reports every active fault with its display code.
// - Clear-faults, or disable followed by enable, clears active faults.
// - A fault-list read with nothing active reports a no-faults indication.
// - Mode 0: hardware enable rising edge clears faults; mode 1: it does not.
// - The hardware enable level always gates whether the drive is active.
// - An enable command while software enable is low clears faults.
module drive_enable_fault_supervisor
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic hw_enable_in,
	input wire logic default_sw_enable,
	input wire logic [`SRC_W-1:0] command_source_select,
	input wire logic [`FAULT_NUM-1:0] fault_in,
	input wire logic cmd_valid,
	input wire drive_pkg::cmd_t cmd_code,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [`DATA_W-1:0] reg_wdata,
	output logic [`DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	output logic sw_enable_state,
	output logic drive_active,
	output logic [`FAULT_NUM-1:0] active_faults,
	output logic [`HIST_PTR_W-1:0] history_count,
	output logic rsp_valid,
	output logic [`CODE_W-1:0] rsp_code,
	output logic [`STAMP_W-1:0] rsp_stamp,
	output logic rsp_last,
	output logic rsp_none
);
	import drive_pkg::*;

	drive_pkg::sup_state_t s;
	drive_pkg::sup_state_t n;
	logic [`CODE_W-1:0] hist_code [0:`HIST_DEPTH-1];
	logic [`STAMP_W-1:0] hist_stamp [0:`HIST_DEPTH-1];
	logic hw_level;
	logic hw_rise;
	logic [`FAULT_NUM-1:0] new_faults;
	logic log_en;
	logic hist_clr;
	logic [`FAULT_IDX_W-1:0] log_idx;

	// Display code of a fault source.
	function automatic logic [`CODE_W-1:0] fault_code(
		input logic [`FAULT_IDX_W-1:0] idx);
		fault_code = `FAULT_CODE_BASE + `CODE_W'(idx);
	endfunction

	// History pointer step forward with wrap.
	function automatic logic [`HIST_PTR_W-1:0] ptr_inc(
		input logic [`HIST_PTR_W-1:0] p);
		ptr_inc = (p == `HIST_LAST) ? `HIST_ZERO : p + `HIST_ONE;
	endfunction

	// History pointer step back with wrap.
	function automatic logic [`HIST_PTR_W-1:0] ptr_dec(
		input logic [`HIST_PTR_W-1:0] p);
		ptr_dec = (p == `HIST_ZERO) ? `HIST_LAST : p - `HIST_ONE;
	endfunction

	// Lowest set bit of a fault vector.
	function automatic logic [`FAULT_IDX_W-1:0] first_set(
		input logic [`FAULT_NUM-1:0] v);
		first_set = '0;
		for (int i = `FAULT_NUM - 1; i >= 0; i--)
			if (v[i])
				first_set = `FAULT_IDX_W'(i);
	endfunction

	enable_edge_detect u_hw_edge
	(
		.clk(clk),
		.resetn(resetn),
		.din(hw_enable_in),
		.level(hw_level),
		.rise(hw_rise)
	);

	// New faults are the ones rising this cycle; only one is logged per
	// cycle, so simultaneous onsets keep only the lowest source in history.
	assign new_faults = fault_in & ~s.active;
	assign log_en = |new_faults;
	assign log_idx = first_set(new_faults);
	assign hist_clr = cmd_valid && (cmd_code == CMD_HIST_CLEAR);

	// Next-state logic for the whole supervisor.
	always_comb
	begin
		logic clear_all;
		clear_all = 1'b0;
		n = s;
		n.stamp = s.stamp + `STAMP_ONE;
		n.rsp_valid = 1'b0;
		n.rsp_last = 1'b0;
		n.rsp_none = 1'b0;
		n.reg_rvalid = 1'b0;
		if (!s.boot_done)
		begin
			n.boot_done = 1'b1;
			if (command_source_select != `CMD_SOURCE_NO_FIELDBUS)
				n.sw_enable = default_sw_enable;
		end
		if (cmd_valid)
		begin
			case (cmd_code)
				CMD_SW_ENABLE:
				begin
					if (!s.sw_enable)
						clear_all = 1'b1;
					n.sw_enable = 1'b1;
				end
				CMD_SW_DISABLE:
					n.sw_enable = 1'b0;
				CMD_FAULT_CLEAR:
					clear_all = 1'b1;
				CMD_FAULT_LIST:
				begin
					if (s.rd_state == RD_IDLE)
					begin
						if (s.active == '0)
						begin
							n.rsp_valid = 1'b1;
							n.rsp_none = 1'b1;
							n.rsp_last = 1'b1;
						end
						else
						begin
							n.snap = s.active;
							n.scan_idx = '0;
							n.rd_state = RD_FAULTS;
						end
					end
				end
				CMD_HIST_READ:
				begin
					if (s.rd_state == RD_IDLE)
					begin
						if (s.count == `HIST_ZERO)
						begin
							n.rsp_valid = 1'b1;
							n.rsp_none = 1'b1;
							n.rsp_last = 1'b1;
						end
						else
						begin
							n.rd_ptr = ptr_dec(s.wr_ptr);
							n.rd_left = s.count;
							n.rd_state = RD_HIST;
						end
					end
				end
				default:
					n.sw_enable = s.sw_enable;
			endcase
		end
		if (hw_rise && (s.hw_mode == `HWEN_MODE_CLEARS))
			clear_all = 1'b1;
		// A fault present in the clearing cycle survives: set wins.
		n.active = (clear_all ? '0 : s.active) | fault_in;
		n.drive_active = hw_level & n.sw_enable & ~(|n.active);
		if (hist_clr)
		begin
			n.count = log_en ? `HIST_ONE : `HIST_ZERO;
			if (s.rd_state == RD_HIST)
				n.rd_state = RD_IDLE;
		end
		else if (log_en && (s.count != `HIST_FULL))
			n.count = s.count + `HIST_ONE;
		if (log_en)
			n.wr_ptr = ptr_inc(s.wr_ptr);
		// Read engine emits at most one entry per cycle; a fault-list read steps one source per cycle.
		case (s.rd_state)
			// A new fault-list read scans from source 0; the old index
			// would skip the sources below where the last scan stopped.
			RD_IDLE:
				n.scan_idx = (n.rd_state == RD_FAULTS) ?
					'0 : s.scan_idx;
			RD_FAULTS:
			begin
				if (s.snap[s.scan_idx])
				begin
					n.rsp_valid = 1'b1;
					n.rsp_code = fault_code(s.scan_idx);
					n.rsp_stamp = '0;
					n.rsp_last = ((s.snap >> s.scan_idx) >> 1) == '0;
					if (n.rsp_last)
						n.rd_state = RD_IDLE;
				end
				n.scan_idx = s.scan_idx + `FAULT_IDX_W'(1);
			end
			RD_HIST:
			begin
				if (!hist_clr)
				begin
					n.rsp_valid = 1'b1;
					n.rsp_code = hist_code[s.rd_ptr];
					n.rsp_stamp = hist_stamp[s.rd_ptr];
					n.rsp_last = (s.rd_left == `HIST_ONE);
					n.rd_left = s.rd_left - `HIST_ONE;
					n.rd_ptr = ptr_dec(s.rd_ptr);
					if (n.rsp_last)
						n.rd_state = RD_IDLE;
				end
			end
			default:
				n.rd_state = RD_IDLE;
		endcase
		// Mode register; only bit 0 is stored, the rest read as zero.
		if (reg_wr && (reg_addr == `HWEN_MODE_ADDR))
			n.hw_mode = reg_wdata[0];
		if (reg_rd)
		begin
			n.reg_rvalid = 1'b1;
			n.reg_rdata = (reg_addr == `HWEN_MODE_ADDR) ?
				`DATA_W'(s.hw_mode) : '0;
		end
	end

	// State register with defined reset values.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.hw_mode <= `HWEN_MODE_RESET;
		end
		else
			s <= n;
	end

	always_ff @(posedge clk)
	begin
		if (log_en)
		begin
			hist_code[s.wr_ptr] <= fault_code(log_idx);
			hist_stamp[s.wr_ptr] <= s.stamp;
		end
	end

	assign reg_rdata = s.reg_rdata;
	assign reg_rvalid = s.reg_rvalid;
	assign sw_enable_state = s.sw_enable;
	assign drive_active = s.drive_active;
	assign active_faults = s.active;
	assign history_count = s.count;
	assign rsp_valid = s.rsp_valid;
	assign rsp_code = s.rsp_code;
	assign rsp_stamp = s.rsp_stamp;
	assign rsp_last = s.rsp_last;
	assign rsp_none = s.rsp_none;

	// Checks on the supervisor's outputs and state and on the edge detector.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	AST_BOOT_LOAD: assert property (
		$rose(s.boot_done) && !$past(cmd_valid) |->
		s.sw_enable == (($past(command_source_select) !=
		`CMD_SOURCE_NO_FIELDBUS) ? $past(default_sw_enable) : 1'b0))
		else $error("software enable not loaded from default");
	AST_HIST_COUNT: assert property (
		log_en && !hist_clr |=> s.count == (($past(s.count) ==
		`HIST_FULL) ? `HIST_FULL : $past(s.count) + `HIST_ONE))
		else $error("history count did not follow a new fault");
	AST_HIST_CLEAR: assert property (
		hist_clr && !log_en |=> s.count == `HIST_ZERO)
		else $error("history not emptied");
	AST_FAULT_REPORT: assert property (
		s.rd_state == RD_FAULTS && s.snap[s.scan_idx] |=>
		s.rsp_valid && !s.rsp_none &&
		s.rsp_code == fault_code($past(s.scan_idx)))
		else $error("active fault not reported with its code");
	AST_CLEAR_CMD: assert property (
		cmd_valid && cmd_code == CMD_FAULT_CLEAR |=>
		s.active == $past(fault_in))
		else $error("clear command left faults active");
	AST_NO_FAULTS: assert property (
		cmd_valid && cmd_code == CMD_FAULT_LIST &&
		s.rd_state == RD_IDLE && s.active == '0 |=>
		s.rsp_valid && s.rsp_none && s.rsp_last)
		else $error("no-faults indication missing");
	AST_HW_CLEAR: assert property (
		hw_rise && s.hw_mode == `HWEN_MODE_CLEARS |=>
		s.active == $past(fault_in))
		else $error("hardware enable edge did not clear faults");
	AST_HW_KEEP: assert property (
		hw_rise && s.hw_mode == `HWEN_MODE_KEEPS && !cmd_valid |=>
		(s.active & $past(s.active)) == $past(s.active))
		else $error("hardware enable edge cleared faults in mode 1");
	AST_ACTIVE_GATE: assert property (
		!hw_level |=> !s.drive_active)
		else $error("drive active with hardware enable low");
	AST_EN_CLEAR: assert property (
		cmd_valid && cmd_code == CMD_SW_ENABLE && !s.sw_enable |=>
		s.active == $past(fault_in) && s.sw_enable)
		else $error("enable from disabled did not clear faults");
	AST_RISE_PULSE: assert property (
		hw_rise |-> hw_level ##1 !hw_rise)
		else $error("enable rise is not a single pulse");
	AST_HIST_WRAP: assert property (
		log_en && s.wr_ptr == `HIST_LAST |=> s.wr_ptr == `HIST_ZERO)
		else $error("history pointer did not wrap");

	COV_TWO_FAULTS: cover property (
		s.rsp_valid && !s.rsp_last ##[1:16] s.rsp_valid && s.rsp_last);
	COV_NONE: cover property (s.rsp_valid && s.rsp_none);
	COV_FULL: cover property (log_en && s.count == `HIST_FULL);
	COV_HW_CLEAR: cover property (
		hw_rise && s.hw_mode == `HWEN_MODE_CLEARS && s.active != '0);

endmodule

// ### verilog/drive_params.svh
/*
 Named constants for the drive enable and fault supervisor.
 Assumes it is included by the package and by every design module.
*/
`ifndef DRIVE_PARAMS_SVH
`define DRIVE_PARAMS_SVH

// Fault sources and the codes shown on the front display.
`define FAULT_NUM 16
`define FAULT_IDX_W 4
`define FAULT_IDX_LAST 4'hf
`define CODE_W 16
// Arbitrary base for display codes; source n shows base plus n.
`define FAULT_CODE_BASE 16'h01f5

// Fault history geometry.
`define HIST_DEPTH 50
`define HIST_PTR_W 6
`define HIST_FULL 6'd50
`define HIST_LAST 6'd49
`define HIST_ZERO 6'd0
`define HIST_ONE 6'd1
`define STAMP_W 32
`define STAMP_ONE 32'h1

// Register map.
`define ADDR_W 12
`define DATA_W 32
`define HWEN_MODE_ADDR 12'h104
`define HWEN_MODE_RESET 1'b0
`define HWEN_MODE_CLEARS 1'b0
`define HWEN_MODE_KEEPS 1'b1

// Command source setting.
`define SRC_W 4
`define CMD_SOURCE_NO_FIELDBUS 4'h1

`endif

// ### verilog/drive_pkg.sv
/*
 Types shared by the supervisor and its edge detector.
 Assumes drive_params.svh is reachable on the include path.
*/
`include "drive_params.svh"

package drive_pkg;

	// Host commands on the command port.
	typedef enum logic [2:0]
	{
		CMD_NONE = 3'h0,
		CMD_SW_ENABLE = 3'h1,
		CMD_SW_DISABLE = 3'h2,
		CMD_FAULT_CLEAR = 3'h3,
		CMD_HIST_CLEAR = 3'h4,
		CMD_FAULT_LIST = 3'h5,
		CMD_HIST_READ = 3'h6
	} cmd_t;

	// Read engine states, Gray coded along idle, faults, history.
	typedef enum logic [1:0]
	{
		RD_IDLE = 2'b00,
		RD_FAULTS = 2'b01,
		RD_HIST = 2'b11
	} rd_state_t;

	typedef struct packed
	{
		logic s1;
		logic s2;
		logic prev;
		logic rise;
	} edge_state_t;

	typedef struct packed
	{
		logic boot_done;
		logic sw_enable;
		logic drive_active;
		logic hw_mode;
		logic [`FAULT_NUM-1:0] active;
		logic [`FAULT_NUM-1:0] snap;
		logic [`HIST_PTR_W-1:0] wr_ptr;
		logic [`HIST_PTR_W-1:0] count;
		logic [`STAMP_W-1:0] stamp;
		rd_state_t rd_state;
		logic [`FAULT_IDX_W-1:0] scan_idx;
		logic [`HIST_PTR_W-1:0] rd_ptr;
		logic [`HIST_PTR_W-1:0] rd_left;
		logic rsp_valid;
		logic [`CODE_W-1:0] rsp_code;
		logic [`STAMP_W-1:0] rsp_stamp;
		logic rsp_last;
		logic rsp_none;
		logic reg_rvalid;
		logic [`DATA_W-1:0] reg_rdata;
	} sup_state_t;

endpackage

// ### verilog/enable_edge_detect.sv
/*
 Two-stage synchroniser and rising-edge detector for the hardware enable.
 Assumes din may change at any time relative to clk.
*/
`include "drive_params.svh"

module enable_edge_detect
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic din,
	output logic level,
	output logic rise
);
	import drive_pkg::*;

	drive_pkg::edge_state_t s_reg;
	drive_pkg::edge_state_t s_next;

	// Only the second stage looks at the first; level and rise stay aligned.
	always_comb
	begin
		s_next = s_reg;
		s_next.s1 = din;
		s_next.s2 = s_reg.s1;
		s_next.prev = s_reg.s2;
		s_next.rise = s_reg.s2 & ~s_reg.prev;
	end

	// State register.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign level = s_reg.prev;
	assign rise = s_reg.rise;

endmodule

// ### sim/field_model.sv
/*
 Field side model: hardware enable pin and the fault sources.
 Assumes the bench calls its tasks just after a rising clock edge.
*/
`include "drive_params.svh"

module field_model
(
	input wire logic clk,
	output logic hw_enable_in,
	output logic [`FAULT_NUM-1:0] fault_in
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		hw_enable_in = 1'b0;
		fault_in = '0;
	end

	// A source rises for two cycles, then drops so that it can rise again.
	task automatic pulse_fault(input int idx);
		fault_in[idx] = 1'b1;
		repeat (2) @(posedge clk);
		#1 fault_in = '0;
		@(posedge clk);
		#1;
	endtask

	// The pin settles for six cycles, longer than the synchroniser delay.
	task automatic set_hw(input logic v);
		hw_enable_in = v;
		repeat (6) @(posedge clk);
		#1;
	endtask
endmodule

// ### sim/tb_drive_enable_fault_supervisor.sv
/*
 Self-checking bench for the drive enable and fault supervisor.
 Assumes drive_pkg and the field model are compiled before it.
*/
`include "drive_params.svh"

module tb_drive_enable_fault_supervisor;
	timeunit 1ns;
	timeprecision 100ps;
	import drive_pkg::*;

	logic clk, resetn, dflt, cmd_valid, reg_wr, reg_rd, hw_en;
	logic [3:0] src;
	cmd_t cmd_code;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, q, stamp, w;
	logic reg_rvalid, sw_en, drive_active, rsp_valid, rsp_last, rsp_none;
	logic [15:0] faults, active_faults, rsp_code, m, first;
	logic [5:0] history_count;
	logic nn, ok, lst;
	int miscompares = 0, checks_done = 0, n, a, b;

	field_model i_field_model (.clk(clk), .hw_enable_in(hw_en),
		.fault_in(faults));

	drive_enable_fault_supervisor i_drive_enable_fault_supervisor (
		.clk(clk), .resetn(resetn), .hw_enable_in(hw_en),
		.default_sw_enable(dflt), .command_source_select(src),
		.fault_in(faults), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .sw_enable_state(sw_en),
		.drive_active(drive_active), .active_faults(active_faults),
		.history_count(history_count), .rsp_valid(rsp_valid),
		.rsp_code(rsp_code), .rsp_stamp(stamp), .rsp_last(rsp_last),
		.rsp_none(rsp_none));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Expected display code of a fault source.
	function automatic logic [15:0] code_of(input int idx);
		return `FAULT_CODE_BASE + 16'(idx);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic do_reset(input logic d, input logic [3:0] s);
		resetn = 1'b0;
		dflt = d;
		src = s;
		repeat (16) @(posedge clk);
		#1 resetn = 1'b1;
		@(posedge clk);
		#1;
	endtask

	task automatic do_cmd(input cmd_t c);
		@(posedge clk);
		#1 cmd_valid = 1'b1;
		cmd_code = c;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		cmd_code = CMD_NONE;
	endtask

	// One register cycle; the read answer is taken one edge later.
	task automatic reg_rw(input logic w, input logic [11:0] ad,
		input logic [31:0] d);
		@(posedge clk);
		#1 reg_wr = w;
		reg_rd = !w;
		reg_addr = ad;
		reg_wdata = d;
		@(posedge clk);
		#1 reg_wr = 1'b0;
		reg_rd = 1'b0;
		q = reg_rdata;
		check(reg_rvalid, !w);
	endtask

	// Collects a list reply: source mask, newest code, count, stamp order.
	task automatic read_list(input cmd_t c);
		m = '0;
		n = 0;
		nn = 1'b0;
		lst = 1'b0;
		ok = 1'b1;
		q = '1;
		do_cmd(c);
		// The empty-list reply already stands right after the command edge.
		repeat (60)
		begin
			nn |= rsp_none;
			if (rsp_valid === 1'b1 && rsp_none === 1'b0)
			begin
				if (n == 0)
					first = rsp_code;
				m |= 16'h1 << (rsp_code - `FAULT_CODE_BASE);
				ok &= (c != CMD_HIST_READ) || (stamp < q);
				ok &= (c != CMD_FAULT_LIST) || (stamp == '0);
				ok &= !lst;
				lst = rsp_last;
				q = stamp;
				n++;
			end
			@(posedge clk);
			#1;
		end
	endtask

	task automatic test_end(input string name);
		$display("test %s done", name);
	endtask

	initial
	begin
		{cmd_valid, reg_wr, reg_rd, resetn} = '0;
		cmd_code = CMD_NONE;
		{reg_addr, reg_wdata} = '0;
		void'($urandom(33));
		// boot load with a random default and a random source with bit 1 set, so never 1.
		do_reset(1'($urandom), 4'($urandom) | 4'h2);
		check(sw_en, dflt);
		reg_rw(1'b0, `HWEN_MODE_ADDR, '0);
		check(q, 32'h0);
		reg_rw(1'b1, `HWEN_MODE_ADDR, 32'hffffffff);
		reg_rw(1'b0, `HWEN_MODE_ADDR, '0);
		check(q, 32'h1);
		w = $urandom;
		reg_rw(1'b1, `HWEN_MODE_ADDR, w);
		reg_rw(1'b1, 12'($urandom) & 12'heff, 32'h0);
		reg_rw(1'b0, `HWEN_MODE_ADDR, '0);
		check(q, {31'h0, w[0]});
		reg_rw(1'b0, 12'($urandom) & 12'heff, '0);
		check(q, 32'h0);
		reg_rw(1'b1, `HWEN_MODE_ADDR, '0);
		test_end("registers");
		a = 1 + $urandom % 14;
		b = 1 + (a + $urandom % 13) % 14;
		i_field_model.pulse_fault(0);
		i_field_model.pulse_fault(15);
		i_field_model.pulse_fault(a);
		read_list(CMD_FAULT_LIST);
		check(m, 16'h8001 | (16'h1 << a));
		check(nn, 1'b0);
		check({ok, lst}, 2'b11);
		check(history_count, 6'd3);
		read_list(CMD_HIST_READ);
		check(first, code_of(a));
		check({lst, n[5:0]}, {1'b1, 6'd3});
		do_cmd(CMD_FAULT_CLEAR);
		check(active_faults, 16'h0);
		read_list(CMD_FAULT_LIST);
		check({nn, m}, {1'b1, 16'h0});
		test_end("fault list");
		// enable clears only from the disabled state
		i_field_model.pulse_fault(a);
		do_cmd(CMD_SW_ENABLE);
		check(active_faults, dflt ? 16'h1 << a : 16'h0);
		do_cmd(CMD_SW_DISABLE);
		check(sw_en, 1'b0);
		do_cmd(CMD_SW_ENABLE);
		check({sw_en, active_faults}, {1'b1, 16'h0});
		test_end("enable");
		i_field_model.set_hw(1'b1);
		check(drive_active, 1'b1);
		i_field_model.set_hw(1'b0);
		check(drive_active, 1'b0);
		i_field_model.pulse_fault(b);
		i_field_model.set_hw(1'b1);
		check(active_faults, 16'h0);
		reg_rw(1'b1, `HWEN_MODE_ADDR, 32'h1);
		i_field_model.set_hw(1'b0);
		i_field_model.pulse_fault(b);
		i_field_model.set_hw(1'b1);
		check(active_faults, 16'h1 << b);
		check(drive_active, 1'b0);
		test_end("hardware enable");
		do_cmd(CMD_HIST_CLEAR);
		check(history_count, 6'd0);
		read_list(CMD_HIST_READ);
		check({nn, n[5:0]}, {1'b1, 6'd0});
		// Overrun the history so that the oldest entries are dropped.
		repeat (52)
		begin
			a = $urandom % 16;
			do_cmd(CMD_FAULT_CLEAR);
			i_field_model.pulse_fault(a);
		end
		check(history_count, `HIST_FULL);
		read_list(CMD_HIST_READ);
		check({ok, lst, n[5:0], first}, {2'b11, `HIST_FULL, code_of(a)});
		test_end("history");
		do_reset(1'b1, `CMD_SOURCE_NO_FIELDBUS);
		check(sw_en, 1'b0);
		test_end("fieldbus boot");
		final_report();
	end

	initial
	begin
		#60000;
		miscompares++;
		final_report();
	end
endmodule
